// [rtl/bopd_diag_top.sv]
// service diagnostic pattern generator of the bus option port
`timescale 1ns/1ns
`include "bopd_cfg.svh"
module bopd_diag_top #(
  parameter int DYN_HALF_CYC = `BOPD_SYS_HZ / (2 * `BOPD_DYN_HZ),
  parameter int REPEAT_CYC = `BOPD_REPEAT_NS / `BOPD_SYS_NS,
  parameter int BIT_CYC = (`BOPD_SYS_HZ + `BOPD_BAUD / 2) / `BOPD_BAUD
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // strap and switches, asynchronous pins
  input wire logic diag_strap_point_a_i,
  input wire logic mode_select_switch_hi_i,
  input wire logic mode_select_switch_mid_i,
  input wire logic mode_select_switch_lo_i,
  // status
  output logic diag_active_o,
  output logic [7:0] error_code_o,
  output bopd_pkg::bopd_mode_type diag_mode_o,
  output logic [7:0] rd_data_o,
  // port 0
  output logic [7:0] p0_o,
  output logic [7:0] p0_oe_n_o,
  // port 1
  input wire logic [7:0] p1_i,
  output logic [7:0] p1_o,
  output logic [7:0] p1_oe_n_o,
  // port 2
  output logic [7:0] p2_o,
  output logic [7:0] p2_oe_n_o,
  // port 3
  output logic [7:0] p3_o,
  output logic [7:0] p3_oe_n_o,
  // controller chip strobes
  output logic chip_data_strobe_n_o,
  output logic chip_read_o
);
  import bopd_pkg::*;

  localparam int CTRL_CYC = `BOPD_SYS_HZ / `BOPD_CTRL_CLK_HZ;
  localparam int CTRL_HI_CYC = CTRL_CYC / 2;
  localparam int DW = $clog2(DYN_HALF_CYC + 1);
  localparam int RW = $clog2(REPEAT_CYC + 1);

  if (DYN_HALF_CYC < 1 || CTRL_CYC < 2 || REPEAT_CYC <= `BOPD_FRAME_BITS * BIT_CYC)
  begin : g_bad_param
    $error("bopd_diag_top: timing parameters cannot be served");
  end

  logic strap_sync;
  logic [2:0] sw_sync;
  logic [7:0] p1_sync;
  logic [1:0] start_cnt;
  logic diag_active;
  bopd_mode_type mode;
  logic [DW-1:0] dyn_cnt;
  logic dyn_phase;
  logic [7:0] dyn_pat;
  logic [2:0] clk_cnt;
  logic ctrl_clk;
  bopd_rw_state_type rw_state;
  logic [2:0] strobe_cnt;
  logic rw_is_read;
  logic [7:0] rw_data;
  logic [RW-1:0] rep_cnt;
  logic tx_line;
  logic [7:0] next_p0;
  logic [7:0] next_p0_oe_n;
  logic [7:0] next_p1;
  logic [7:0] next_p1_oe_n;

  bopd_tx_if tx_link ();

  bopd_sync #(.W(1)) u_strap_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(diag_strap_point_a_i),
    .sync_o(strap_sync)
  );
  bopd_sync #(.W(3)) u_sw_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({mode_select_switch_hi_i, mode_select_switch_mid_i, mode_select_switch_lo_i}),
    .sync_o(sw_sync)
  );
  bopd_sync #(.W(8)) u_p1_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(p1_i),
    .sync_o(p1_sync)
  );

  // strap is caught once, when the synchroniser has settled after release
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      start_cnt <= 2'h0;
      diag_active <= 1'b0;
    end else begin
      if (start_cnt != 2'h3) begin
        start_cnt <= start_cnt + 2'h1;
      end
      if (start_cnt == 2'h2) begin
        diag_active <= strap_sync;
      end
    end
  end
  // no clear path: only a reset leaves the mode, strap removal matters next time

  always_comb begin
    if (!sw_sync[2]) begin
      mode = BOPD_MODE_RW;
    end else if (!sw_sync[0]) begin
      mode = BOPD_MODE_DYNAMIC;
    end else if (sw_sync[1]) begin
      mode = BOPD_MODE_STATIC_EVEN;
    end else begin
      mode = BOPD_MODE_STATIC_ODD;
    end
  end

  assign diag_active_o = diag_active;
  assign diag_mode_o = mode;
  assign error_code_o = diag_active ? `BOPD_ERROR_CODE : 8'h00;

  // square wave runs free so a switch change lands on a clean phase
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dyn_cnt <= '0;
      dyn_phase <= 1'b0;
    end else if (dyn_cnt == DW'(DYN_HALF_CYC - 1)) begin
      dyn_cnt <= '0;
      dyn_phase <= ~dyn_phase;
    end else begin
      dyn_cnt <= dyn_cnt + 1'b1;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_dyn_bit
    assign dyn_pat[g] = (g % 2 == 1) ? dyn_phase : ~dyn_phase;
  end

  // 20 MHz cannot give an even 4 MHz; duty is two high, three low
  // parked at the wrap so the first pulse after entry is full width
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_cnt <= 3'(CTRL_CYC - 1);
      ctrl_clk <= 1'b0;
    end else if (!diag_active) begin
      clk_cnt <= 3'(CTRL_CYC - 1);
      ctrl_clk <= 1'b0;
    end else begin
      clk_cnt <= (clk_cnt == 3'(CTRL_CYC - 1)) ? 3'h0 : clk_cnt + 3'h1;
      ctrl_clk <= (clk_cnt == 3'(CTRL_CYC - 1)) || (clk_cnt < 3'(CTRL_HI_CYC - 1));
    end
  end

  // read/write loop, alternating direction on every access
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rw_state <= BOPD_RW_IDLE;
      strobe_cnt <= 3'h0;
      rw_is_read <= 1'b0;
      rw_data <= 8'h00;
      rd_data_o <= 8'h00;
      chip_data_strobe_n_o <= 1'b1;
    end else if (!diag_active || mode != BOPD_MODE_RW) begin
      rw_state <= BOPD_RW_IDLE;
      chip_data_strobe_n_o <= 1'b1;
    end else begin
      unique case (rw_state)
        BOPD_RW_IDLE: begin
          rw_state <= BOPD_RW_SETUP;
        end
        BOPD_RW_SETUP: begin
          rw_state <= BOPD_RW_STROBE;
          strobe_cnt <= 3'(`BOPD_STROBE_CYC - 1);
          chip_data_strobe_n_o <= 1'b0;
        end
        BOPD_RW_STROBE: begin
          if (strobe_cnt == 3'h0) begin
            rw_state <= BOPD_RW_RECOVER;
            chip_data_strobe_n_o <= 1'b1;
            rw_data <= rw_data + 8'h01;
            if (rw_is_read) begin
              rd_data_o <= p1_sync;
            end
          end else begin
            strobe_cnt <= strobe_cnt - 3'h1;
          end
        end
        BOPD_RW_RECOVER: begin
          rw_state <= BOPD_RW_SETUP;
          rw_is_read <= ~rw_is_read;
        end
      endcase
    end
  end
  assign chip_read_o = rw_is_read;

  always_comb begin
    next_p0 = 8'h00;
    next_p0_oe_n = 8'hff;
    next_p1 = 8'h00;
    next_p1_oe_n = 8'hff;
    if (diag_active) begin
      next_p0_oe_n = ~`BOPD_P0_DRIVE_MASK;
      next_p1_oe_n = 8'h00;
      unique case (mode)
        BOPD_MODE_STATIC_ODD: begin
          next_p1 = 8'hff;
        end
        BOPD_MODE_STATIC_EVEN: begin
          next_p0 = `BOPD_P0_DRIVE_MASK;
        end
        BOPD_MODE_DYNAMIC: begin
          next_p0 = dyn_pat & `BOPD_P0_DRIVE_MASK;
          next_p1 = dyn_pat;
        end
        BOPD_MODE_RW: begin
          next_p0 = {4'h0, `BOPD_RW_ADDR};
          next_p1 = rw_data;
          next_p1_oe_n = rw_is_read ? 8'hff : 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      p0_o <= 8'h00;
      p0_oe_n_o <= 8'hff;
      p1_o <= 8'h00;
      p1_oe_n_o <= 8'hff;
    end else begin
      p0_o <= next_p0;
      p0_oe_n_o <= next_p0_oe_n;
      p1_o <= next_p1;
      p1_oe_n_o <= next_p1_oe_n;
    end
  end

  // port 2 stays an input in every mode because of board conflicts
  assign p2_o = 8'h00;
  assign p2_oe_n_o = 8'hff;

  // repeat timer for the guard-crossing byte
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rep_cnt <= '0;
    end else if (!diag_active || rep_cnt == RW'(REPEAT_CYC - 1)) begin
      rep_cnt <= '0;
    end else begin
      rep_cnt <= rep_cnt + 1'b1;
    end
  end
  assign tx_link.start = diag_active && rep_cnt == '0;
  assign tx_link.data = `BOPD_TX_BYTE;

  bopd_serial_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .tx(tx_link),
    .line_o(tx_line)
  );

  always_comb begin
    p3_o = 8'h00;
    p3_o[`BOPD_P3_CLK_BIT] = ctrl_clk;
    p3_o[`BOPD_P3_TX_BIT] = tx_line;
    p3_oe_n_o = 8'hff;
    p3_oe_n_o[`BOPD_P3_CLK_BIT] = ~diag_active;
    p3_oe_n_o[`BOPD_P3_TX_BIT] = ~diag_active;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_error_code: assert property (diag_active |-> error_code_o == 8'h32)
    else $error("error code not shown in diagnostics");
  chk_no_exit: assert property ($past(diag_active) |-> diag_active)
    else $error("diagnostics left without reset");
  chk_mode_decode: assert property ((mode == BOPD_MODE_RW) == !sw_sync[2])
    else $error("read/write decode wrong");
  chk_static_odd: assert property (diag_active && mode == BOPD_MODE_STATIC_ODD
    && $stable(mode) |=> p1_o == 8'hff && p0_o[3:0] == 4'h0)
    else $error("static odd pattern wrong");
  chk_static_even: assert property (diag_active && mode == BOPD_MODE_STATIC_EVEN
    && $stable(mode) |=> p1_o == 8'h00 && p0_o[3:0] == 4'hf)
    else $error("static even pattern wrong");
  chk_dyn_half: assert property ($changed(dyn_phase) |-> ##1 $stable(dyn_phase) [*8])
    else $error("square wave half period too short");
  chk_dyn_anti: assert property (diag_active && mode == BOPD_MODE_DYNAMIC
    && $stable(mode) |=> p1_o[0] != p1_o[1] && p0_o[2] != p0_o[3])
    else $error("odd and even bits not in antiphase");
  chk_rw_addr: assert property (!chip_data_strobe_n_o |->
    p0_o[3:0] == 4'h3 && p0_oe_n_o[3:0] == 4'h0)
    else $error("address not 0011 during strobe");
  chk_rw_dir: assert property (!chip_data_strobe_n_o |->
    p1_oe_n_o == (chip_read_o ? 8'hff : 8'h00))
    else $error("data direction wrong during strobe");
  chk_rw_width: assert property ($fell(chip_data_strobe_n_o) |->
    !chip_data_strobe_n_o [*4] ##1 chip_data_strobe_n_o)
    else $error("strobe width wrong");
  chk_rw_incr: assert property ($rose(chip_data_strobe_n_o) && diag_active
    |-> rw_data == $past(rw_data) + 8'h01)
    else $error("data not incremented after access");
  chk_never_drive: assert property (p2_oe_n_o == 8'hff && p0_oe_n_o[7:4] == 4'hf
    && p3_oe_n_o[4:1] == 4'hf)
    else $error("forbidden port bit driven");
  chk_ctrl_clock: assert property (diag_active && $rose(ctrl_clk) |->
    ctrl_clk [*2] ##1 !ctrl_clk [*3] ##1 ctrl_clk)
    else $error("controller clock period wrong");
  chk_tx_byte: assert property (tx_link.start && !tx_link.busy |->
    tx_link.data == 8'h55 ##1 !tx_line)
    else $error("serial byte not started");

  cov_static: cover property (diag_active && mode == BOPD_MODE_STATIC_ODD);
  cov_dynamic: cover property (diag_active && $changed(dyn_phase));
  cov_read: cover property ($rose(chip_data_strobe_n_o) && chip_read_o);
  cov_tx: cover property (diag_active && $fell(tx_line));
endmodule : bopd_diag_top

// [rtl/bopd_cfg.svh]
// constants of the bus-option port diagnostic
// How it works
// - strap at power-up enters diagnostics, shows code 50
// - diagnostics end only by reset or power cycle, not by strap removal
// - three switches decode into four modes
// - static mode holds outputs, middle switch picks level
// - switches 101: odd ports high, even ports low
// - dynamic mode toggles outputs at 610 Hz evenly
// - odd bits run in antiphase to even bits
// - read/write mode loops reads and writes with strobe
// - controller address stays 0011 on every access
// - data value increments after each access
// - never drive P0 upper nibble, P2, P3[4:1]
// - port 3 bit 6: 4 MHz controller clock
// - serial 0x55 at 62000 baud every 820 us
`ifndef BOPD_CFG_SVH
`define BOPD_CFG_SVH
`define BOPD_SYS_HZ 20000000
`define BOPD_SYS_NS 50
`define BOPD_CTRL_CLK_HZ 4000000
`define BOPD_DYN_HZ 610
`define BOPD_BAUD 62000
`define BOPD_REPEAT_NS 820000
`define BOPD_ERROR_CODE 8'h32
`define BOPD_RW_ADDR 4'h3
`define BOPD_TX_BYTE 8'h55
`define BOPD_STROBE_CYC 4
`define BOPD_P0_DRIVE_MASK 8'h0f
`define BOPD_P3_CLK_BIT 6
`define BOPD_P3_TX_BIT 7
`define BOPD_FRAME_BITS 10
`endif

// [rtl/bopd_pkg.sv]
// types of the bus-option port diagnostic
package bopd_pkg;
  typedef enum logic [1:0] {
    BOPD_MODE_STATIC_ODD = 2'b00,
    BOPD_MODE_STATIC_EVEN = 2'b01,
    BOPD_MODE_DYNAMIC = 2'b11,
    BOPD_MODE_RW = 2'b10
  } bopd_mode_type;
  typedef enum logic [1:0] {
    BOPD_RW_IDLE = 2'b00,
    BOPD_RW_SETUP = 2'b01,
    BOPD_RW_STROBE = 2'b11,
    BOPD_RW_RECOVER = 2'b10
  } bopd_rw_state_type;
endpackage : bopd_pkg

// [rtl/bopd_tx_if.sv]
// carrier between the pattern core and the serial sender
`timescale 1ns/1ns
interface bopd_tx_if;
  logic start;
  logic [7:0] data;
  logic busy;
  modport src (output start, output data, input busy);
  modport snk (input start, input data, output busy);
endinterface : bopd_tx_if

// [rtl/bopd_sync.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module bopd_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : bopd_sync

// [rtl/bopd_serial_tx.sv]
// 8n1 serial sender, lsb first
`timescale 1ns/1ns
module bopd_serial_tx #(
  parameter int BIT_CYC = 323
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // request
  bopd_tx_if.snk tx,
  // line
  output logic line_o
);
  import bopd_pkg::*;
  localparam int CW = $clog2(BIT_CYC + 1);

  logic [8:0] shift;
  logic [3:0] bits_left;
  logic [CW-1:0] cyc_cnt;
  logic running;

  if (BIT_CYC < 2) begin : g_bad_bit
    $error("bopd_serial_tx: BIT_CYC too small");
  end

  assign tx.busy = running;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift <= 9'h1ff;
      bits_left <= 4'h0;
      cyc_cnt <= '0;
      running <= 1'b0;
      line_o <= 1'b1;
    end else if (tx.start && !running) begin
      line_o <= 1'b0;
      shift <= {1'b1, tx.data};
      bits_left <= 4'h9;
      cyc_cnt <= CW'(BIT_CYC - 1);
      running <= 1'b1;
    end else if (running) begin
      if (cyc_cnt != '0) begin
        cyc_cnt <= cyc_cnt - 1'b1;
      end else if (bits_left != 4'h0) begin
        line_o <= shift[0];
        shift <= {1'b1, shift[8:1]};
        bits_left <= bits_left - 4'h1;
        cyc_cnt <= CW'(BIT_CYC - 1);
      end else begin
        running <= 1'b0;
      end
    end
  end

  chk_start_bit_len: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $fell(line_o) |-> !line_o [*2])
    else $error("start bit shorter than two cycles");
endmodule : bopd_serial_tx

// [tb/bopd_far_model.sv]
// far side model: controller chip read answers and guard-side serial receiver
`timescale 1ns/1ns
module bopd_far_model #(
  parameter int BIT_CYC = 4
) (
  // clock
  input wire logic sys_clk_i,
  // controller chip side
  input wire logic chip_data_strobe_n_i,
  input wire logic chip_read_i,
  output logic [7:0] p1_o,
  output logic [7:0] rd_val_o,
  // guard-side serial
  input wire logic line_i,
  output logic [7:0] rx_byte_o,
  output int rx_count_o,
  output int rx_gap_o
);
  int cyc = 0;
  int last = 0;
  logic seen = 1'b0;
  logic [7:0] b;
  initial begin
    p1_o = 8'h5a;
    rd_val_o = 8'h3c;
    rx_byte_o = 8'h00;
    rx_count_o = 0;
    rx_gap_o = 0;
  end
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (!chip_data_strobe_n_i && chip_read_i) begin
      p1_o <= rd_val_o;
      seen <= 1'b1;
    end else begin
      // released bus shows no stale value
      p1_o <= ~p1_o;
      if (seen) begin
        seen <= 1'b0;
        rd_val_o <= rd_val_o + 8'h13;
      end
    end
  end
  // sample mid-bit on the falling clock to stay clear of line updates
  always begin
    wait (line_i === 1'b1);
    @(negedge line_i);
    rx_gap_o = cyc - last;
    last = cyc;
    repeat (BIT_CYC / 2) @(negedge sys_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(negedge sys_clk_i);
      b[i] = line_i;
    end
    repeat (BIT_CYC) @(negedge sys_clk_i);
    rx_byte_o = (line_i === 1'b1) ? b : 8'hee;
    rx_count_o++;
  end
endmodule : bopd_far_model

// [tb/tb.sv]
// testbench of the bus-option port diagnostic
`timescale 1ns/1ns
module tb;
  import bopd_pkg::*;
  localparam int DYN = 10;
  localparam int BITC = 4;
  localparam int REP = 60;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b0;
  logic [2:0] sw = 3'b000;
  logic [7:0] p1_in;
  logic diag_active;
  logic strobe_n;
  logic chip_rd;
  logic [7:0] err, rd_data, p0, p0_oe_n, p1, p1_oe_n, p2, p2_oe_n, p3, p3_oe_n;
  logic [7:0] rd_val, rx_byte;
  bopd_mode_type mode;
  int rx_count, rx_gap;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;

  always #25 sys_clk = ~sys_clk;

  bopd_diag_top #(.DYN_HALF_CYC(DYN), .REPEAT_CYC(REP), .BIT_CYC(BITC)) i_bopd_diag_top (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .diag_strap_point_a_i(strap),
    .mode_select_switch_hi_i(sw[2]), .mode_select_switch_mid_i(sw[1]),
    .mode_select_switch_lo_i(sw[0]), .diag_active_o(diag_active), .error_code_o(err),
    .diag_mode_o(mode), .rd_data_o(rd_data), .p0_o(p0), .p0_oe_n_o(p0_oe_n),
    .p1_i(p1_in), .p1_o(p1), .p1_oe_n_o(p1_oe_n), .p2_o(p2), .p2_oe_n_o(p2_oe_n),
    .p3_o(p3), .p3_oe_n_o(p3_oe_n), .chip_data_strobe_n_o(strobe_n), .chip_read_o(chip_rd));

  bopd_far_model #(.BIT_CYC(BITC)) i_bopd_far_model (
    .sys_clk_i(sys_clk), .chip_data_strobe_n_i(strobe_n), .chip_read_i(chip_rd),
    .p1_o(p1_in), .rd_val_o(rd_val), .line_i(p3[7]), .rx_byte_o(rx_byte),
    .rx_count_o(rx_count), .rx_gap_o(rx_gap));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk_n(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_n

  task results;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results

  // strap held steady across release so the capture edge sees it
  task do_reset(input logic s, input logic [2:0] m);
    @(posedge sys_clk);
    reset_n <= 1'b0;
    strap <= s;
    sw <= m;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (6) @(negedge sys_clk);
  endtask : do_reset

  task automatic wait_chg(output int n);
    logic [7:0] prev;
    prev = p1;
    n = 0;
    while (p1 === prev && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_chg

  task t_off;
    do_reset(1'b0, 3'b101);
    chk8({7'h0, diag_active}, 8'h00);
    chk8(err, 8'h00);
    chk8(p0_oe_n & p1_oe_n & p3_oe_n, 8'hff);
  endtask : t_off

  task t_static;
    do_reset(1'b1, 3'b101);
    chk8({7'h0, diag_active}, 8'h01);
    chk8(err, 8'h32);
    chk8({6'h0, mode}, {6'h0, BOPD_MODE_STATIC_ODD});
    chk8(p0_oe_n, 8'hf0);
    chk8(p1_oe_n, 8'h00);
    chk8(p3_oe_n, 8'h3f);
    chk8(p1, 8'hff);
    chk8({4'h0, p0[3:0]}, 8'h00);
    repeat (30) @(negedge sys_clk);
    chk8(p1, 8'hff);
    @(posedge sys_clk);
    sw <= 3'b111;
    strap <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk8({6'h0, mode}, {6'h0, BOPD_MODE_STATIC_EVEN});
    chk8(p1, 8'h00);
    chk8({4'h0, p0[3:0]}, 8'h0f);
    chk8({7'h0, diag_active}, 8'h01);
    chk8(err, 8'h32);
  endtask : t_static

  task t_dyn;
    int n;
    @(posedge sys_clk);
    sw <= 3'b100;
    repeat (5) @(negedge sys_clk);
    chk8({6'h0, mode}, {6'h0, BOPD_MODE_DYNAMIC});
    wait_chg(n);
    wait_chg(n);
    chk_n(n, DYN);
    chk8(p1 ^ {p1[0], p1[7:1]}, 8'hff);
    chk8({4'h0, p0[3:0]}, {4'h0, p1[3:0]});
    wait_chg(n);
    chk_n(n, DYN);
  endtask : t_dyn

  task t_rw;
    int n;
    logic [7:0] exp;
    @(posedge sys_clk);
    sw <= 3'b010;
    for (int k = 0; k < 6; k++) begin
      n = 0;
      while (strobe_n !== 1'b0 && n < 20) begin
        @(negedge sys_clk);
        n++;
      end
      chk8({6'h0, mode}, {6'h0, BOPD_MODE_RW});
      chk8({7'h0, chip_rd}, {7'h0, k[0]});
      chk8({4'h0, p0[3:0]}, 8'h03);
      chk8(p1_oe_n, k[0] ? 8'hff : 8'h00);
      if (!k[0]) chk8(p1, k[7:0]);
      exp = rd_val;
      n = 0;
      while (strobe_n === 1'b0 && n < 20) begin
        @(negedge sys_clk);
        n++;
      end
      chk_n(n, 4);
      if (k[0]) chk8(rd_data, exp);
    end
  endtask : t_rw

  task t_link;
    int n, c;
    n = 0;
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk);
      if (p3[6] === 1'b1) n++;
    end
    chk_n(n, 4);
    c = rx_count;
    n = 0;
    while (rx_count < c + 3 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    chk_n(rx_count - c, 3);
    chk8(rx_byte, 8'h55);
    chk_n(rx_gap, REP);
  endtask : t_link

  // pins that must never be driven, watched every cycle
  always @(negedge sys_clk) begin
    if (reset_n) begin
      chk8(p0_oe_n | 8'h0f, 8'hff);
      chk8(p2_oe_n, 8'hff);
      chk8(p2, 8'h00);
      chk8(p3_oe_n | 8'he1, 8'hff);
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    t_off();
    t_static();
    t_dyn();
    t_rw();
    t_link();
    results();
  end
endmodule : tb
